// [dv/bus_host.sv]
// Two-wire bus host model issuing START and STOP
`timescale 1ns/100ps
module bus_host (
  input wire clk_i, // Bench clock
  output reg scl_o, // Bus clock, driven high at idle by this model
  output reg sda_o // Bus data, driven high at idle by this model
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Data falls while clock high, then clock low to hold the access
  task start;
    begin
      @(posedge clk_i) sda_o <= 1'b0;
      repeat (5) @(posedge clk_i);
      scl_o <= 1'b0;
    end
  endtask
  // Data rises while clock high; normal use closes well inside the limit
  task stop;
    begin
      @(posedge clk_i) scl_o <= 1'b1;
      repeat (5) @(posedge clk_i);
      sda_o <= 1'b1;
    end
  endtask
endmodule

// [dv/rtc_pwrup_clkout_sva.sv]
// Checker for the clock-output loader and bus watchdog
`timescale 1ns/100ps
module rtc_pwrup_clkout_sva (
  input wire sys_clk_i, // Clock
  input wire rst_n_i, // Reset, active low
  input wire nv_clock_out_enable_i, // Stored enable
  input wire [2:0] clock_out_freq_select_i, // Select
  input wire clock_output_pin_o, // Pin
  input wire clock_out_enable_o, // Enable copy
  input wire load_done_o, // Load finished
  input wire bus_active_o, // Access open
  input wire bus_reset_o // Watchdog pulse
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Two cycles of held state allow for the registered pin
  a_sel_low: assert property (clock_out_freq_select_i == 3'h7 && $past(clock_out_freq_select_i) == 3'h7
    |-> !clock_output_pin_o) else $error("pin runs with select all ones");
  a_en_low: assert property (!clock_out_enable_o && !$past(clock_out_enable_o) |-> !clock_output_pin_o)
    else $error("pin runs with enable clear");
  a_en_early: assert property (!load_done_o |-> clock_out_enable_o) else $error("enable clear before load");
  a_load_copy: assert property ($rose(load_done_o) |-> clock_out_enable_o == $past(nv_clock_out_enable_i))
    else $error("enable copy differs from stored value");
  a_en_hold: assert property (load_done_o |=> $stable(clock_out_enable_o)) else $error("enable moved");
  a_done_hold: assert property (load_done_o |=> load_done_o) else $error("load flag dropped");
  a_rst_pulse: assert property (bus_reset_o |=> !bus_reset_o) else $error("bus reset too long");
  a_rst_cause: assert property (bus_reset_o |-> !bus_active_o && $past(bus_active_o))
    else $error("bus reset without open access");
endmodule
bind rtc_pwrup_clkout rtc_pwrup_clkout_sva chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .nv_clock_out_enable_i(nv_clock_out_enable_i), .clock_out_freq_select_i(clock_out_freq_select_i),
  .clock_output_pin_o(clock_output_pin_o), .clock_out_enable_o(clock_out_enable_o),
  .load_done_o(load_done_o), .bus_active_o(bus_active_o), .bus_reset_o(bus_reset_o));

// [dv/test_rtc_powerup_clkout_and_bus_timeout.sv]
// Self-checking bench for the loader and bus watchdog
`timescale 1ns/100ps
`include "rtc_pwrup_map.vh"
module test_rtc_powerup_clkout_and_bus_timeout;
  reg clk = 1'b0, rst_n = 1'b0, osc = 1'b0, nv = 1'b0;
  reg [2:0] sel = 3'h0;
  wire scl, sda, pin, en, done, act, brst;
  integer mismatches = 0, tests_run = 0, n, t0;
  // Oscillator runs free at 800 ns, each of its edges landing on a falling edge of the bench clock
  always #50 clk = ~clk;
  always #400 osc = ~osc;
  bus_host h (.clk_i(clk), .scl_o(scl), .sda_o(sda));
  rtc_pwrup_clkout dut (.sys_clk_i(clk), .rst_n_i(rst_n), .osc_clk_i(osc), .nv_clock_out_enable_i(nv),
    .clock_out_freq_select_i(sel), .scl_i(scl), .sda_i(sda), .clock_output_pin_o(pin),
    .clock_out_enable_o(en), .load_done_o(done), .bus_active_o(act), .bus_reset_o(brst));
  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask
  task check(input got, input exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Counts pin changes over 40 cycles, sampled after the edge settles
  task edges;
    reg p;
    begin
      n = 0;
      p = pin;
      repeat (40) begin
        @(posedge clk) #1 if (pin !== p) n = n + 1;
        p = pin;
      end
    end
  endtask
  // Bounded wait on load flag or watchdog pulse; running out ends the run
  task wait_on(input w);
    begin
      n = 0;
      while ((w ? brst : done) !== 1'b1 && n < 300000) begin
        @(posedge clk) #1 n = n + 1;
      end
      if (n >= 300000) begin
        mismatches = mismatches + 1;
        test_done;
      end
    end
  endtask
  // Output runs from reset with the enable copy active
  task t_run;
    begin
      repeat (10) @(posedge clk);
      #1 check(en, 1'b1);
      edges;
      check(n > 4, 1'b1);
      $display("t_run done");
    end
  endtask
  // All-ones select holds the pin low
  task t_low;
    begin
      @(posedge clk);
      sel <= 3'h7;
      repeat (3) @(posedge clk);
      edges;
      check(n == 0 && pin === 1'b0, 1'b1);
      @(posedge clk);
      sel <= 3'h0;
      $display("t_low done");
    end
  endtask
  // Short access opens and closes the watchdog
  task t_quick;
    begin
      h.start;
      repeat (20) @(posedge clk);
      #1 check(act, 1'b1);
      h.stop;
      repeat (20) @(posedge clk);
      #1 check(act, 1'b0);
      $display("t_quick done");
    end
  endtask
  // Stored enable zero clears the copy; an open access times out
  task t_long;
    begin
      h.start;
      t0 = $time;
      wait_on(1'b0);
      check(en, 1'b0);
      repeat (2) @(posedge clk);
      edges;
      check(n == 0 && pin === 1'b0, 1'b1);
      wait_on(1'b1);
      check(($time - t0) / 100 > (`TIMEOUT_TICKS - 1) * 8 && ($time - t0) / 100 < (`TIMEOUT_TICKS + 2) * 8, 1'b1);
      check(act, 1'b0);
      h.stop;
      $display("t_long done");
    end
  endtask
  // Mid-run reset with stored enable one; copy stays set and 8192 Hz runs
  task t_set;
    begin
      @(posedge clk);
      rst_n <= 1'b0;
      nv <= 1'b1;
      sel <= 3'h1;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk) #1 check(en, 1'b1);
      check(done, 1'b0);
      wait_on(1'b0);
      check(en, 1'b1);
      repeat (2) @(posedge clk);
      edges;
      check(n >= 2, 1'b1);
      $display("t_set done");
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_run;
    t_low;
    t_quick;
    t_long;
    t_set;
    test_done;
  end
endmodule

// [rtl/pin_sync.v]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync (
  input wire sys_clk_i, // System clock
  input wire rst_n_i,   // Async reset, active low
  input wire pin_i,     // Asynchronous pin
  output reg level_o    // Filtered level
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  // ============================================================
  // Stage one is read only by stage two; level moves when two and three agree
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_o <= s3_q;
      end
    end
  end
endmodule

// [rtl/rtc_pwrup_clkout.v]
// Power-up clock-output enable loader and two-wire bus access watchdog
//
// Overview of operation
// - Clock output runs from reset, enable defaults active
// - Select code all-ones holds output low
// - Stored enable zero clears copy after refresh
// - Stored enable one sets copy after refresh
// - Output toggles only while enable copy set
// - Access lasting 950 ms resets bus interface
`timescale 1ns/100ps
`include "rtc_pwrup_map.vh"
module rtc_pwrup_clkout (
  input wire sys_clk_i,                              // System clock, 10 MHz
  input wire rst_n_i,                                // Power-on reset, active low
  input wire osc_clk_i,                              // 32.768 kHz oscillator
  input wire nv_clock_out_enable_i,                  // Stored enable at config byte 35h
  input wire [`FSEL_W-1:0] clock_out_freq_select_i,  // Output frequency select
  input wire scl_i,                                  // Bus clock pin
  input wire sda_i,                                  // Bus data pin
  output reg clock_output_pin_o,                     // Clock output pin
  output reg clock_out_enable_o,                     // RAM copy of the enable
  output reg load_done_o,                            // Power-up load finished
  output reg bus_active_o,                           // Access between START and STOP
  output reg bus_reset_o                             // One-cycle bus interface reset
);
  localparam ST_START = 3'h1;
  localparam ST_REFR = 3'h2;
  localparam ST_DONE = 3'h4;

  wire osc_lvl;
  wire scl_lvl;
  wire sda_lvl;
  reg osc_prev_q;
  reg scl_prev_q;
  reg sda_prev_q;
  reg [2:0] state_q;
  reg [`CNT_W-1:0] pcnt_q;
  reg [`CNT_W-1:0] wcnt_q;
  reg [`DIV_W-1:0] div_q;
  reg sel_bit;
  wire osc_rise;
  wire start_cond;
  wire stop_cond;

  // ============================================================
  // Input synchronisers
  // Every pin from outside the system clock passes three flip-flops and an
  // agreement filter, so a single metastable sample never reaches the logic.
  // The price is three to four cycles of latency on each pin, which is far
  // below one oscillator period and far below any bus timing that matters.
  // Oscillator input; its filtered rising edges are the time base
  pin_sync u_osc (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(osc_clk_i),
    .level_o(osc_lvl)
  );

  // Bus clock pin
  pin_sync u_scl (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(scl_i),
    .level_o(scl_lvl)
  );

  // Bus data pin; same latency as the clock pin keeps their order intact
  pin_sync u_sda (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(sda_i),
    .level_o(sda_lvl)
  );

  // ============================================================
  // Edge and bus condition detection on filtered levels
  // Both bus pins share one latency, so a data change while the clock is
  // high is seen as START or STOP exactly as the host placed it.
  assign osc_rise = osc_lvl & ~osc_prev_q;
  assign start_cond = scl_lvl & scl_prev_q & sda_prev_q & ~sda_lvl;
  assign stop_cond = scl_lvl & scl_prev_q & ~sda_prev_q & sda_lvl;

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_prev_q <= 1'b0;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      osc_prev_q <= osc_lvl;
      scl_prev_q <= scl_lvl;
      sda_prev_q <= sda_lvl;
    end
  end

  // ============================================================
  // Power-up loader: start-up wait, then first refresh, then copy stored enable
  // The copy starts active so the output runs during the refresh wait
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_START;
      pcnt_q <= {`CNT_W{1'b0}};
      clock_out_enable_o <= 1'b1;
      load_done_o <= 1'b0;
    end else begin
      case (state_q)
        ST_START: begin
          if (osc_rise) begin
            if (pcnt_q == `STARTUP_TICKS - 1) begin
              pcnt_q <= {`CNT_W{1'b0}};
              state_q <= ST_REFR;
            end else begin
              pcnt_q <= pcnt_q + 1'b1;
            end
          end
        end
        ST_REFR: begin
          if (osc_rise) begin
            if (pcnt_q == `REFRESH_TICKS - 1) begin
              clock_out_enable_o <= nv_clock_out_enable_i;
              load_done_o <= 1'b1;
              state_q <= ST_DONE;
            end else begin
              pcnt_q <= pcnt_q + 1'b1;
            end
          end
        end
        ST_DONE: begin
          state_q <= ST_DONE;
        end
        default: begin
          state_q <= ST_START;
        end
      endcase
    end
  end

  // ============================================================
  // Output divider; runs from the oscillator so frequencies stay exact
  // The divider is free running from reset; the selected output therefore
  // starts at an arbitrary phase, which is harmless for a clock output.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q <= {`DIV_W{1'b0}};
    end else if (osc_rise) begin
      div_q <= div_q + 1'b1;
    end
  end

  // ============================================================
  // Select tap: 32768, 8192, 1024, 64, 32, 1 Hz; code 6 falls back to 1 Hz
  // Code 7 lands on the default tap here, but the pin stage holds it low.
  always @* begin
    case (clock_out_freq_select_i)
      `FSEL_32K: begin
        sel_bit = osc_lvl;
      end
      `FSEL_8K: begin
        sel_bit = div_q[`TAP_8K];
      end
      `FSEL_1K: begin
        sel_bit = div_q[`TAP_1K];
      end
      `FSEL_64: begin
        sel_bit = div_q[`TAP_64];
      end
      `FSEL_32: begin
        sel_bit = div_q[`TAP_32];
      end
      default: begin
        sel_bit = div_q[`TAP_1HZ];
      end
    endcase
  end

  // ============================================================

  // Output pin: low when disabled or on the all-ones code
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clock_output_pin_o <= 1'b0;
    end else if (!clock_out_enable_o) begin
      clock_output_pin_o <= 1'b0;
    end else if (clock_out_freq_select_i == `FSEL_LOW) begin
      clock_output_pin_o <= 1'b0;
    end else begin
      clock_output_pin_o <= sel_bit;
    end
  end

  // ============================================================
  // Bus watchdog: counts oscillator ticks from START; STOP or timeout ends it
  // Ticks while idle are ignored, so a quiet bus never fires the reset.
  // STOP wins over START in one cycle, closing the access cleanly.
  // A repeated START restarts the count, which limits each segment only
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wcnt_q <= {`CNT_W{1'b0}};
      bus_active_o <= 1'b0;
      bus_reset_o <= 1'b0;
    end else begin
      bus_reset_o <= 1'b0;
      if (stop_cond) begin
        wcnt_q <= {`CNT_W{1'b0}};
        bus_active_o <= 1'b0;
      end else if (start_cond) begin
        wcnt_q <= {`CNT_W{1'b0}};
        bus_active_o <= 1'b1;
      end else if (bus_active_o && osc_rise) begin
        if (wcnt_q == `TIMEOUT_TICKS - 1) begin
          wcnt_q <= {`CNT_W{1'b0}};
          bus_active_o <= 1'b0;
          bus_reset_o <= 1'b1;
        end else begin
          wcnt_q <= wcnt_q + 1'b1;
        end
      end
    end
  end
endmodule

// [rtl/rtc_pwrup_map.vh]
// Constants for the power-up clock-output loader and the bus watchdog
`ifndef RTC_PWRUP_MAP_VH
`define RTC_PWRUP_MAP_VH
// ============================================================
// Timing figures
`define STARTUP_MS 500
`define REFRESH_MS 66
`define BUS_TIMEOUT_MS 950
`define OSC_HZ 32768
// Oscillator ticks per interval; start-up and refresh round up as least times
`define STARTUP_TICKS ((`STARTUP_MS * `OSC_HZ + 999) / 1000)
`define REFRESH_TICKS ((`REFRESH_MS * `OSC_HZ + 999) / 1000)
`define TIMEOUT_TICKS ((`BUS_TIMEOUT_MS * `OSC_HZ + 999) / 1000)
// ============================================================
// Field values
`define NV_ADDR_CLOCK_OUT_ENABLE 8'h35
`define FSEL_W 3
`define FSEL_LOW 3'h7
// Select codes for the running frequencies
`define FSEL_32K 3'h0
`define FSEL_8K 3'h1
`define FSEL_1K 3'h2
`define FSEL_64 3'h3
`define FSEL_32 3'h4
// Divider taps; bit k of the divider runs at 32768 / 2^(k+1) Hz
`define TAP_8K 1
`define TAP_1K 4
`define TAP_64 8
`define TAP_32 9
`define TAP_1HZ 14
`define CNT_W 16
`define DIV_W 15
`endif
